// [rtl/pasl_pkg.sv]
// Package of constants for the address strap and status LED pins
// Behaviour
// [RULE1] While hardware or power-on reset is held the link pin is an input that sets address bit 2.
// [RULE2] A low strap level gives an address bit of zero and a high level gives one.
// [RULE3] After reset the link pin drives its asserted level while a valid link exists.
// [RULE4] While hardware or power-on reset is held the transmit pin is an input that sets address bit 3.
// [RULE5] After reset the transmit pin shows transmit activity and is deasserted when idle.
// [RULE6] After reset the receive pin is asserted while there is receive activity.
// [RULE7] While hardware or power-on reset is held the receive pin sets address bit 4.
// [RULE8] Each strap level is latched as reset is left and the pin then turns to an output.
// [RULE9] The asserted output level is the inverse of the level latched on that pin.
// [RULE10] A software reset neither resamples the straps nor stops the pins driving.
package pasl_pkg;
   localparam int unsigned NUM_PINS = 3;
   localparam int unsigned ADDR_LSB = 2;          // Strap pins hold address bits 2..4
   localparam logic [2:0] STRAP_RST = 3'h0;       // Latched straps after reset
   localparam int unsigned PIN_LINK = 0;
   localparam int unsigned PIN_TX   = 1;
   localparam int unsigned PIN_RX   = 2;
endpackage

// [rtl/pasl_sync.sv]
// Two-flop synchroniser for the strap pin inputs
`timescale 1ns/1ps
module pasl_sync #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             i_clk,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } pasl_sync_s;

   pasl_sync_s st_r;
   pasl_sync_s st_nxt;

   // Meta stage feeds only the second stage
   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = i_async;
      st_nxt.sync = st_r.meta;
   end

   // Stages keep sampling through reset so the straps are seen before it ends
   always_ff @(posedge i_clk) begin
      st_r <= st_nxt;
   end

   assign o_sync = st_r.sync;
endmodule

// [rtl/pasl_strap_led.sv]
// Address strap capture and status LED drive on three shared pins
`timescale 1ns/1ps
module pasl_strap_led (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_link_up,
   input  wire logic       i_tx_act,
   input  wire logic       i_rx_act,
   input  wire logic       i_addr2_link_led_pin,
   input  wire logic       i_addr3_tx_led_pin,
   input  wire logic       i_addr4_rx_led_pin,
   output logic            o_addr2_link_led_pin,
   output logic            o_addr3_tx_led_pin,
   output logic            o_addr4_rx_led_pin,
   output logic            o_addr2_link_led_pin_oe,
   output logic            o_addr3_tx_led_pin_oe,
   output logic            o_addr4_rx_led_pin_oe,
   output logic [2:0]      o_phy_addr_hi
);
   localparam int unsigned N = pasl_pkg::NUM_PINS;

   typedef struct packed {
      logic         in_rst;    // High through hardware reset and for the one cycle after it is released
      logic [N-1:0] strap;     // Latched strap levels
      logic [N-1:0] led;       // Driven pin levels
      logic         oe;        // Pins are outputs
   } pasl_state_s;

   pasl_state_s st_r;
   pasl_state_s st_nxt;
   logic [N-1:0] pin_in;
   logic [N-1:0] pin_sync;
   logic [N-1:0] status;
   logic [N-1:0] drv_seen;
   logic [N-1:0] oe_seen;

   // Per-pin vectors: bit 0 link, bit 1 transmit, bit 2 receive
   assign pin_in = {i_addr4_rx_led_pin, i_addr3_tx_led_pin, i_addr2_link_led_pin};
   assign status = {i_rx_act, i_tx_act, i_link_up};
   assign drv_seen = {o_addr4_rx_led_pin, o_addr3_tx_led_pin, o_addr2_link_led_pin};
   assign oe_seen  = {o_addr4_rx_led_pin_oe, o_addr3_tx_led_pin_oe, o_addr2_link_led_pin_oe};

   // Strap pins cross into the clock domain before any use
   pasl_sync #(
      .WIDTH (N)
   ) u_sync (
      .i_clk   (i_clk),
      .i_async (pin_in),
      .o_sync  (pin_sync)
   );

   // Capture straps on reset exit, then drive inverted-sense status
   always_comb begin
      st_nxt        = st_r;
      st_nxt.in_rst = 1'b0;
      if (st_r.in_rst) begin
         st_nxt.strap = pin_sync;                        // RULE1 RULE2 RULE4 RULE7 RULE8
         st_nxt.oe    = 1'b1;                            // RULE8
         st_nxt.led   = pin_sync;                        // Deasserted level first
      end else begin
         for (int i = 0; i < N; i++) begin
            st_nxt.led[i] = status[i] ^ st_r.strap[i];   // RULE3 RULE5 RULE6 RULE9
         end
      end
   end

   // Hardware reset floats the pins; soft reset is outside this block
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r.in_rst <= 1'b1;                            // RULE1
         st_r.strap  <= pasl_pkg::STRAP_RST;
         st_r.led    <= pasl_pkg::STRAP_RST;
         st_r.oe     <= 1'b0;
      end else begin
         st_r <= st_nxt;                                 // RULE10
      end
   end

   assign o_addr2_link_led_pin    = st_r.led[pasl_pkg::PIN_LINK];
   assign o_addr3_tx_led_pin      = st_r.led[pasl_pkg::PIN_TX];
   assign o_addr4_rx_led_pin      = st_r.led[pasl_pkg::PIN_RX];
   assign o_addr2_link_led_pin_oe = st_r.oe;
   assign o_addr3_tx_led_pin_oe   = st_r.oe;
   assign o_addr4_rx_led_pin_oe   = st_r.oe;
   assign o_phy_addr_hi           = st_r.strap;

   // Assertions
   // Pins float while hardware reset is held
   property p_float_in_rst;
      @(posedge i_clk) i_rst |=> !o_addr2_link_led_pin_oe;
   endproperty
   a_float_in_rst: assert property (p_float_in_rst) else $error("pins driven in reset"); // RULE1

   // Address takes the synchronised straps on the exit edge
   property p_latch;
      @(posedge i_clk) disable iff (i_rst) st_r.in_rst |=> o_phy_addr_hi == $past(pin_sync);
   endproperty
   a_latch: assert property (p_latch) else $error("strap not latched"); // RULE8

   // Address stays put while the pins drive
   property p_addr_hold;
      @(posedge i_clk) disable iff (i_rst) o_addr2_link_led_pin_oe |=> $stable(o_phy_addr_hi);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address changed"); // RULE10

   // Link output follows link state in the inverted sense
   property p_link;
      @(posedge i_clk) disable iff (i_rst)
         (o_addr2_link_led_pin_oe && !st_r.in_rst) |=>
         o_addr2_link_led_pin == ($past(i_link_up) ^ o_phy_addr_hi[0]);
   endproperty
   a_link: assert property (p_link) else $error("link led wrong"); // RULE3

   // Idle transmit shows the deasserted level
   property p_tx;
      @(posedge i_clk) disable iff (i_rst)
         (o_addr3_tx_led_pin_oe && !i_tx_act) |=> o_addr3_tx_led_pin == o_phy_addr_hi[1];
   endproperty
   a_tx: assert property (p_tx) else $error("tx led wrong"); // RULE5

   // Receive activity shows the asserted level
   property p_rx;
      @(posedge i_clk) disable iff (i_rst)
         (o_addr4_rx_led_pin_oe && i_rx_act) |=> o_addr4_rx_led_pin != o_phy_addr_hi[2];
   endproperty
   a_rx: assert property (p_rx) else $error("rx led wrong"); // RULE6

   // Pins turn to outputs right after reset is left
   property p_oe_after;
      @(posedge i_clk) $fell(i_rst) |-> ##1 o_addr3_tx_led_pin_oe;
   endproperty
   a_oe_after: assert property (p_oe_after) else $error("pins not outputs"); // RULE8

   // Strap level is kept, not inverted, in the address
   property p_level;
      @(posedge i_clk) disable iff (i_rst)
         st_r.in_rst |=> o_phy_addr_hi[1] == $past(pin_sync[1]) && o_addr4_rx_led_pin_oe;
   endproperty
   a_level: assert property (p_level) else $error("strap level wrong"); // RULE2

   // Exit marker lasts exactly one cycle
   property p_in_rst_pulse;
      @(posedge i_clk) disable iff (i_rst)
         st_r.in_rst |=> !st_r.in_rst;
   endproperty
   a_in_rst_pulse: assert property (p_in_rst_pulse) else $error("exit marker stuck"); // RULE8

   // All three pins change direction together
   property p_oe_common;
      @(posedge i_clk) disable iff (i_rst)
         (o_addr2_link_led_pin_oe == o_addr3_tx_led_pin_oe) &&
         (o_addr3_tx_led_pin_oe == o_addr4_rx_led_pin_oe);
   endproperty
   a_oe_common: assert property (p_oe_common) else $error("pin directions differ"); // RULE8

   // Synchroniser passes pin levels two cycles late with the sense unchanged
   property p_sync_follow;
      @(posedge i_clk) disable iff (i_rst)
         pin_sync == $past(pin_in, 2);
   endproperty
   a_sync_follow: assert property (p_sync_follow) else $error("strap level lost"); // RULE2

   // Address moves only on the exit edge or under hardware reset
   property p_addr_src;
      @(posedge i_clk) disable iff (i_rst)
         $changed(o_phy_addr_hi) |-> ($past(st_r.in_rst) || $past(i_rst));
   endproperty
   a_addr_src: assert property (p_addr_src) else $error("address moved late"); // RULE10

   // Per-pin checks: capture, direction and inverted-sense drive
   for (genvar g = 0; g < N; g++) begin : g_pin
      // Each pin latches its own address bit as reset is left
      property p_cap;
         @(posedge i_clk) disable iff (i_rst)
            st_r.in_rst |=> o_phy_addr_hi[g] == $past(pin_sync[g]);
      endproperty
      a_cap: assert property (p_cap) else $error("strap bit lost"); // RULE1 RULE4 RULE7

      // First driven level is the deasserted one, equal to the strap
      property p_dark;
         @(posedge i_clk) disable iff (i_rst)
            st_r.in_rst |=> drv_seen[g] == $past(pin_sync[g]);
      endproperty
      a_dark: assert property (p_dark) else $error("first level wrong"); // RULE9

      // Asserted level is the inverse of the latched strap
      property p_on;
         @(posedge i_clk) disable iff (i_rst)
            (oe_seen[g] && status[g]) |=> drv_seen[g] != o_phy_addr_hi[g];
      endproperty
      a_on: assert property (p_on) else $error("level not inverse"); // RULE3 RULE5 RULE6 RULE9

      // Without its status event the pin shows the deasserted level
      property p_off;
         @(posedge i_clk) disable iff (i_rst)
            (oe_seen[g] && !status[g]) |=> drv_seen[g] == o_phy_addr_hi[g];
      endproperty
      a_off: assert property (p_off) else $error("idle level wrong"); // RULE3 RULE5 RULE6

      // Hardware reset releases the pin and clears its driven level
      property p_rst_float;
         @(posedge i_clk)
            i_rst |=> !oe_seen[g] && !drv_seen[g];
      endproperty
      a_rst_float: assert property (p_rst_float) else $error("pin not released"); // RULE1

      // Once driving, the pin stays an output until hardware reset
      property p_stay;
         @(posedge i_clk) disable iff (i_rst)
            oe_seen[g] |=> oe_seen[g];
      endproperty
      a_stay: assert property (p_stay) else $error("pin stopped driving"); // RULE10

      // Levels driven after exit never reach the address bit
      property p_keep;
         @(posedge i_clk) disable iff (i_rst)
            oe_seen[g] |=> $stable(o_phy_addr_hi[g]);
      endproperty
      a_keep: assert property (p_keep) else $error("address bit moved"); // RULE8
   end

   // Main scenarios worth seeing
   c_link_on:  cover property (@(posedge i_clk) o_addr2_link_led_pin_oe && i_link_up);
   c_tx_on:    cover property (@(posedge i_clk) o_addr3_tx_led_pin_oe && i_tx_act);
   c_rx_on:    cover property (@(posedge i_clk) o_addr4_rx_led_pin_oe && i_rx_act);
   c_strap_hi: cover property (@(posedge i_clk) o_phy_addr_hi == 3'h7);
   c_rereset:  cover property (@(posedge i_clk) $rose(i_rst) && o_addr2_link_led_pin_oe);
endmodule

// [tb/pasl_board.sv]
// Board model: strap resistors and status LEDs on the three shared pins
`timescale 1ns/1ps
module pasl_board (
   input  wire logic [2:0] i_strap,
   input  wire logic [2:0] i_drv,
   input  wire logic [2:0] i_oe,
   output logic      [2:0] o_pin
);
   // A released pin settles to its strap resistor level
   assign o_pin = (i_oe & i_drv) | (~i_oe & i_strap);
endmodule

// [tb/tb_pasl_strap_led.sv]
// Testbench for the strap capture and status LED pins
`timescale 1ns/1ps
module tb_pasl_strap_led;
   logic       i_clk = 1'b0;
   logic       i_rst = 1'b1;
   logic [2:0] act   = 3'h0;
   logic [2:0] strap = 3'h0;
   logic [2:0] pin;
   logic [2:0] drv;
   logic [2:0] oe;
   logic [2:0] addr;
   int         failures = 0;
   int         checks_done = 0;
   // Clock of 4 ns
   always #2 i_clk = ~i_clk;
   pasl_board i_board (.i_strap(strap), .i_drv(drv), .i_oe(oe), .o_pin(pin));
   pasl_strap_led i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_link_up(act[0]), .i_tx_act(act[1]),
      .i_rx_act(act[2]), .i_addr2_link_led_pin(pin[0]), .i_addr3_tx_led_pin(pin[1]),
      .i_addr4_rx_led_pin(pin[2]), .o_addr2_link_led_pin(drv[0]),
      .o_addr3_tx_led_pin(drv[1]), .o_addr4_rx_led_pin(drv[2]),
      .o_addr2_link_led_pin_oe(oe[0]), .o_addr3_tx_led_pin_oe(oe[1]),
      .o_addr4_rx_led_pin_oe(oe[2]), .o_phy_addr_hi(addr));
   // Compare a three-bit result
   task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Advance one edge and drive just after it
   task automatic tick;
      @(posedge i_clk);
      #1;
   endtask
   // Hold reset five cycles with the given straps, then release
   task automatic reset_with(input logic [2:0] s);
      strap = s;
      i_rst = 1'b1;
      repeat (5) tick;
      chk("oe_in_reset", 3'h0, oe);
      chk("out_in_reset", 3'h0, drv);
      i_rst = 1'b0;
      tick;
   endtask
   // Every strap pattern is latched and shown deasserted
   task automatic scen_capture;
      for (int s = 0; s < 8; s++) begin
         reset_with(s[2:0]);
         chk("addr", s[2:0], addr);
         chk("oe", 3'h7, oe);
         chk("idle_out", s[2:0], drv);
      end
   endtask
   // Every activity mix drives inverse-of-strap, address unmoved by pin levels
   task automatic scen_status(input logic [2:0] s);
      reset_with(s);
      for (int a = 0; a < 8; a++) begin
         act = a[2:0];
         tick;
         chk("led_out", a[2:0] ^ s, drv);
         chk("addr_hold", s, addr);
      end
   endtask
   // Reset again mid-run with activity high and the straps left at 2 from the run before
   task automatic scen_rereset;
      act = 3'h7;
      reset_with(3'h2);
      chk("addr_new", 3'h2, addr);
      tick;
      chk("led_new", 3'h5, drv);
   endtask
   // Final report and verdict
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Main sequence
   initial begin
      scen_capture();
      scen_status(3'h5);
      scen_status(3'h2);
      scen_rereset();
      complete_run();
   end
endmodule
